// *** hw/drive_on_off_sequencer.sv ***
// on/off sequencer, torque direction interlock and binary input functions
// assumes terminal inputs are asynchronous; setpoints come from same clock
module dos_drive_on_off_sequencer #(
   parameter int unsigned DataW = 16
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire dos_pkg::dos_term_s   termIn,
   input  wire logic                 parallel_torque_permit_in,
   input  wire logic                 torqueDirRequest,
   input  wire logic                 torqueDirReqTwo,
   input  wire logic [3:0]           force_select_output,
   input  wire logic [3:0]           selectFuncLevel,
   input  wire logic [2:0]           changeover_cmd,
   input  wire logic [3*DataW-1:0]   changeover_default,
   input  wire logic [3*DataW-1:0]   changeover_source,
   input  wire logic                 pot_preset_cmd,
   input  wire logic [DataW-1:0]     pot_preset_source,
   input  wire logic [DataW-1:0]     potNext,
   output dos_pkg::dos_seq_s         seqOut,
   output logic                      brake_open_out,
   output logic [1:0]                torque_direction_signal_out,
   output logic [3:0]                selectOut,
   output logic [3*DataW-1:0]        changeoverOut,
   output logic [DataW-1:0]          potOut
);
   if (DataW < 1 || DataW > 32) begin
      $error("DataW out of range");
   end

   // synchronisers for pin inputs
   logic [10:0] syncA_q;
   logic [10:0] syncB_q;
   always_ff @(posedge clock) begin
      syncA_q <= {termIn, parallel_torque_permit_in, force_select_output};
      syncB_q <= syncA_q;
   end
   dos_pkg::dos_term_s term;
   logic               permit;
   logic [3:0]         forceIn;
   assign term    = syncB_q[10:5];
   assign permit  = syncB_q[4];
   assign forceIn = syncB_q[3:0];

   // registers
   logic [31:0] control_word_q;
   logic [31:0] config_q;
   logic [31:0] brake_open_time_q;
   logic [31:0] brake_close_time_q;
   logic [31:0] field_reduce_delay_q;
   logic [31:0] no_current_interval_q;
   logic [23:0] select_function_q;
   logic [31:0] statusWord;
   logic        wrEn;
   assign wrEn = psel & penable & pwrite & pready;
   always_ff @(posedge clock) begin
      if (rst) begin
         control_word_q        <= dos_pkg::ResetControl;
         config_q              <= dos_pkg::ResetConfig;
         brake_open_time_q     <= dos_pkg::ResetTime;
         brake_close_time_q    <= dos_pkg::ResetTime;
         field_reduce_delay_q  <= dos_pkg::ResetTime;
         no_current_interval_q <= dos_pkg::ResetTime;
         select_function_q     <= dos_pkg::ResetSelFunc;
      end else if (wrEn) begin
         case (paddr)
            dos_pkg::OffControl:    control_word_q        <= pwdata;
            dos_pkg::OffConfig:     config_q              <= pwdata;
            dos_pkg::OffBrakeOpen:  brake_open_time_q     <= pwdata;
            dos_pkg::OffBrakeClose: brake_close_time_q    <= pwdata;
            dos_pkg::OffFieldDelay: field_reduce_delay_q  <= pwdata;
            dos_pkg::OffNoCurrent:  no_current_interval_q <= pwdata;
            dos_pkg::OffSelFunc:    select_function_q     <= pwdata[23:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            case (paddr)
               dos_pkg::OffControl:    prdata <= control_word_q;
               dos_pkg::OffConfig:     prdata <= config_q;
               dos_pkg::OffBrakeOpen:  prdata <= brake_open_time_q;
               dos_pkg::OffBrakeClose: prdata <= brake_close_time_q;
               dos_pkg::OffFieldDelay: prdata <= field_reduce_delay_q;
               dos_pkg::OffNoCurrent:  prdata <= no_current_interval_q;
               dos_pkg::OffSelFunc:    prdata <= {8'h00, select_function_q};
               dos_pkg::OffStatus:     prdata <= statusWord;
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // command sources
   logic [1:0] keySel;
   logic       edgeMode;
   logic       onTermEff;
   logic       enTermEff;
   logic       onLevel;
   logic       enable;
   logic       onPrev_q;
   logic       onCmd_q;
   assign keySel    = config_q[dos_pkg::CfgKeyLsb +: 2];
   assign edgeMode  = config_q[dos_pkg::CfgEdgeBit];
   assign onTermEff = (keySel == dos_pkg::KeyNone) ? term.onTerm : term.panelOnKey;
   // terminal ignored under key setting 2
   assign enTermEff = (keySel == dos_pkg::KeyOnEnable) ? term.panelOnKey : term.enableTerm;
   assign onLevel   = onTermEff & control_word_q[dos_pkg::CtlOnBit];
   // enable ANDed with control bit 3
   assign enable    = enTermEff & control_word_q[dos_pkg::CtlEnableBit];
   always_ff @(posedge clock) begin
      if (rst) begin
         onPrev_q <= 1'b1;
         onCmd_q  <= 1'b0;
      end else begin
         onPrev_q <= onLevel;
         if (!edgeMode) begin
            onCmd_q <= onLevel;
         end else if (!onLevel || !term.stopPushbutton) begin
            onCmd_q <= 1'b0;
         end else if (!onPrev_q) begin
            onCmd_q <= 1'b1; // rising edge with stop high
         end
      end
   end

   // sequencer
   dos_pkg::dos_state_e state_q;
   logic [31:0] timer_q;
   logic [31:0] fieldTimer_q;
   logic        minLatch_q;
   logic        brakeDeferred_q;
   logic        openNeg;
   logic        timerDone;
   assign openNeg   = brake_open_time_q[31];
   assign timerDone = (timer_q == 32'h0000_0000);
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q         <= dos_pkg::DOS_READY;
         timer_q         <= 32'h0000_0000;
         minLatch_q      <= 1'b0;
         brakeDeferred_q <= 1'b0;
      end else begin
         if (!timerDone) timer_q <= timer_q - 32'h0000_0001;
         case (state_q)
            dos_pkg::DOS_READY: begin
               minLatch_q <= 1'b0;
               if (onCmd_q) state_q <= dos_pkg::DOS_CONTACTOR;
            end
            dos_pkg::DOS_CONTACTOR:
               state_q <= onCmd_q ? dos_pkg::DOS_WAIT_ENABLE : dos_pkg::DOS_CURRENT_DECAY;
            dos_pkg::DOS_WAIT_ENABLE: begin
               if (!onCmd_q) begin
                  state_q <= dos_pkg::DOS_CURRENT_DECAY;
               end else if (enable && term.currentZero) begin
                  if (openNeg) begin
                     timer_q         <= -brake_open_time_q;
                     brakeDeferred_q <= 1'b1;
                     state_q         <= dos_pkg::DOS_RUN;
                  end else begin
                     timer_q <= brake_open_time_q;
                     state_q <= dos_pkg::DOS_BRAKE_WAIT;
                  end
               end
            end
            dos_pkg::DOS_BRAKE_WAIT: begin
               if (!enable || !onCmd_q) state_q <= dos_pkg::DOS_WAIT_ENABLE;
               else if (timerDone) state_q <= dos_pkg::DOS_RUN;
            end
            dos_pkg::DOS_RUN: begin
               if (brakeDeferred_q && timerDone) brakeDeferred_q <= 1'b0;
               if (!onCmd_q) begin
                  state_q <= dos_pkg::DOS_RAMP_DOWN;
               end else if (!enable) begin
                  brakeDeferred_q <= 1'b0;
                  state_q         <= dos_pkg::DOS_WAIT_ENABLE;
               end
            end
            dos_pkg::DOS_RAMP_DOWN: begin
               if (term.speedBelowMin || minLatch_q) begin
                  minLatch_q      <= 1'b1;
                  brakeDeferred_q <= 1'b0;
                  timer_q         <= brake_close_time_q;
                  state_q         <= dos_pkg::DOS_BRAKE_CLOSE;
               end
            end
            dos_pkg::DOS_BRAKE_CLOSE:
               if (timerDone) state_q <= dos_pkg::DOS_CURRENT_DECAY;
            dos_pkg::DOS_CURRENT_DECAY:
               if (term.currentZero) state_q <= dos_pkg::DOS_READY;
            default: state_q <= dos_pkg::DOS_READY;
         endcase
      end
   end

   // field reduction delay after ready
   always_ff @(posedge clock) begin
      if (rst || state_q != dos_pkg::DOS_READY) begin
         fieldTimer_q <= field_reduce_delay_q;
      end else if (fieldTimer_q != 32'h0000_0000) begin
         fieldTimer_q <= fieldTimer_q - 32'h0000_0001;
      end
   end

   dos_pkg::dos_seq_s seqNext;
   always_comb begin
      seqNext                  = '0;
      seqNext.readyToSwitchOn  = (state_q == dos_pkg::DOS_READY);
      seqNext.lineContactor    = ~seqNext.readyToSwitchOn;
      seqNext.fieldReduce      = seqNext.readyToSwitchOn && onLevel == 1'b0 &&
                                 fieldTimer_q == 32'h0000_0000;
      seqNext.brakeOpen        = (state_q == dos_pkg::DOS_BRAKE_WAIT) ||
                                 (state_q == dos_pkg::DOS_RUN && !brakeDeferred_q) ||
                                 (state_q == dos_pkg::DOS_RAMP_DOWN && !brakeDeferred_q);
      seqNext.ctrlEnable       = state_q inside {dos_pkg::DOS_RUN, dos_pkg::DOS_RAMP_DOWN,
                                                 dos_pkg::DOS_BRAKE_CLOSE};
      seqNext.currentZeroForce = ~seqNext.ctrlEnable;
      seqNext.pulseInhibit     = ~seqNext.ctrlEnable & term.currentZero;
      seqNext.limitsBypass     = (state_q == dos_pkg::DOS_RAMP_DOWN);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         seqOut         <= '0;
         brake_open_out <= 1'b0;
      end else begin
         seqOut         <= seqNext;
         brake_open_out <= seqNext.brakeOpen;
      end
   end

   // torque direction interlock
   logic [31:0] ncTimer_q;
   dos_pkg::dos_dir_e dir_q;
   dos_pkg::dos_dir_e want;
   logic allowed;
   assign want    = torqueDirReqTwo ? dos_pkg::DOS_DIR_TWO : dos_pkg::DOS_DIR_ONE;
   // low permits one to two, high permits two to one
   assign allowed = permit ? (want == dos_pkg::DOS_DIR_ONE) : (want == dos_pkg::DOS_DIR_TWO);
   always_ff @(posedge clock) begin
      if (rst) begin
         dir_q     <= dos_pkg::DOS_DIR_NONE;
         ncTimer_q <= 32'h0000_0000;
      end else if (torqueDirRequest && want != dir_q) begin
         if (dir_q != dos_pkg::DOS_DIR_NONE) begin
            dir_q     <= dos_pkg::DOS_DIR_NONE;
            ncTimer_q <= no_current_interval_q;
         end else if (ncTimer_q != 32'h0000_0000) begin
            ncTimer_q <= ncTimer_q - 32'h0000_0001;
         end else if (term.currentZero && allowed) begin
            dir_q <= want; // held at none until allowed
         end
      end
   end
   always_ff @(posedge clock) begin
      if (rst) torque_direction_signal_out <= 2'h0;
      else torque_direction_signal_out <= dir_q;
   end

   // select outputs, changeovers and potentiometer
   function automatic logic forced(input logic [5:0] func, input logic setIn,
                                   input logic normal);
      forced = (func == dos_pkg::SelNoFunction) ? setIn : normal;
   endfunction
   always_ff @(posedge clock) begin
      if (rst) begin
         selectOut     <= 4'h0;
         changeoverOut <= '0;
         potOut        <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            // synchronised forceIn bit drives the output only when no function is assigned
            selectOut[i] <= forced(select_function_q[6*i +: 6], forceIn[i],
                                   selectFuncLevel[i]);
         end
         for (int k = 0; k < 3; k++) begin
            changeoverOut[k*DataW +: DataW] <= changeover_cmd[k] ?
               changeover_source[k*DataW +: DataW] :
               changeover_default[k*DataW +: DataW];
         end
         potOut <= pot_preset_cmd ? pot_preset_source : potNext;
      end
   end

   assign statusWord = {20'h00000, dir_q, minLatch_q, brake_open_out,
                        seqOut};

   a_forced_select: assert property (@(posedge clock) disable iff (rst)
      select_function_q[5:0] == dos_pkg::SelNoFunction && !wrEn
      |=> selectOut[0] == $past(forceIn[0]))
      else $error("select output not forced");
   a_pot_preset: assert property (@(posedge clock) disable iff (rst)
      pot_preset_cmd |=> potOut == $past(pot_preset_source))
      else $error("pot preset not loaded");
   a_changeover_def: assert property (@(posedge clock) disable iff (rst)
      !changeover_cmd[0] |=> changeoverOut[DataW-1:0] == $past(changeover_default[DataW-1:0]))
      else $error("changeover default wrong");
   a_ready_contactor: assert property (@(posedge clock) disable iff (rst)
      state_q == dos_pkg::DOS_READY |=> !seqOut.lineContactor)
      else $error("contactor held in ready");
   a_ctrl_after_brake: assert property (@(posedge clock) disable iff (rst)
      $rose(seqOut.ctrlEnable) |->
      $past(state_q, 2) inside {dos_pkg::DOS_BRAKE_WAIT, dos_pkg::DOS_WAIT_ENABLE})
      else $error("controllers enabled early");
   a_no_request_hold: assert property (@(posedge clock) disable iff (rst)
      !torqueDirRequest |=> $stable(dir_q))
      else $error("direction changed without request");
   a_dir_block: assert property (@(posedge clock) disable iff (rst)
      dir_q == dos_pkg::DOS_DIR_NONE && !permit ##1 dir_q != dos_pkg::DOS_DIR_NONE
      |-> dir_q == dos_pkg::DOS_DIR_TWO || $past(permit))
      else $error("blocked direction selected");
   a_min_latch: assert property (@(posedge clock) disable iff (rst)
      state_q == dos_pkg::DOS_RAMP_DOWN && term.speedBelowMin
      |=> state_q == dos_pkg::DOS_BRAKE_CLOSE && minLatch_q)
      else $error("minimum speed not latched");
   c_run: cover property (@(posedge clock) state_q == dos_pkg::DOS_RUN);
   c_shutdown: cover property (@(posedge clock)
      state_q == dos_pkg::DOS_CURRENT_DECAY ##1 state_q == dos_pkg::DOS_READY);
   c_dir_change: cover property (@(posedge clock) $changed(dir_q));
endmodule

// *** hw/dos_pkg.sv ***
// package for the drive on/off sequencer: register map, field layouts, timing
// assumes a 200 MHz computation clock and an APB master with 32-bit data
package dos_pkg;
   localparam int unsigned ClockMhz        = 200;
   // register byte offsets
   localparam logic [7:0] OffControl       = 8'h00;
   localparam logic [7:0] OffConfig        = 8'h04;
   localparam logic [7:0] OffBrakeOpen     = 8'h08;
   localparam logic [7:0] OffBrakeClose    = 8'h0c;
   localparam logic [7:0] OffFieldDelay    = 8'h10;
   localparam logic [7:0] OffNoCurrent     = 8'h14;
   localparam logic [7:0] OffSelFunc       = 8'h18;
   localparam logic [7:0] OffStatus        = 8'h1c;
   // control word bits
   localparam int unsigned CtlOnBit        = 0;
   localparam int unsigned CtlEnableBit    = 3;
   // config register fields
   localparam int unsigned CfgKeyLsb       = 0;
   localparam int unsigned CfgEdgeBit      = 2;
   // key function values
   localparam logic [1:0] KeyNone          = 2'h0;
   localparam logic [1:0] KeyOn            = 2'h1;
   localparam logic [1:0] KeyOnEnable      = 2'h2;
   // select output function meaning no function assigned
   localparam logic [5:0] SelNoFunction    = 6'h02;
   // reset values
   localparam logic [31:0] ResetControl    = 32'h0000_0000;
   localparam logic [31:0] ResetConfig     = 32'h0000_0000;
   localparam logic [31:0] ResetTime       = 32'h0000_0000;
   localparam logic [23:0] ResetSelFunc    = 24'h082082;

   typedef enum {
      DOS_READY, DOS_CONTACTOR, DOS_WAIT_ENABLE, DOS_BRAKE_WAIT, DOS_RUN,
      DOS_RAMP_DOWN, DOS_BRAKE_CLOSE, DOS_CURRENT_DECAY
   } dos_state_e;

   typedef enum logic [1:0] {
      DOS_DIR_NONE = 2'h0, DOS_DIR_ONE = 2'h1, DOS_DIR_TWO = 2'h2
   } dos_dir_e;

   typedef struct packed {
      logic lineContactor;
      logic brakeOpen;
      logic ctrlEnable;
      logic pulseInhibit;
      logic currentZeroForce;
      logic fieldReduce;
      logic limitsBypass;
      logic readyToSwitchOn;
   } dos_seq_s;

   typedef struct packed {
      logic onTerm;
      logic enableTerm;
      logic panelOnKey;
      logic stopPushbutton;
      logic speedBelowMin;
      logic currentZero;
   } dos_term_s;
endpackage

// *** tb/dos_partner.sv ***
// partner model: speed and current feedback of the driven machine
// assumes seqIn comes straight from the sequencer outputs on the same clock
module dos_partner (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire dos_pkg::dos_seq_s seqIn,
   output logic                   speedBelowMin,
   output logic                   currentZero
);
   logic [3:0] rampCnt_q;
   logic [1:0] decayCnt_q;
   // speed is high while controllers run, falls along the ramp when bypassed
   always_ff @(posedge clock) begin
      if (rst)
         rampCnt_q <= 4'hf;
      else if (seqIn.ctrlEnable && !seqIn.limitsBypass)
         rampCnt_q <= 4'h0;
      else if (rampCnt_q != 4'hf)
         rampCnt_q <= rampCnt_q + 4'h1;
   end
   // current decays a few cycles after its setpoint is forced to zero
   always_ff @(posedge clock) begin
      if (rst)
         decayCnt_q <= 2'h3;
      else if (seqIn.ctrlEnable && !seqIn.currentZeroForce)
         decayCnt_q <= 2'h0;
      else if (decayCnt_q != 2'h3)
         decayCnt_q <= decayCnt_q + 2'h1;
   end
   assign speedBelowMin = rampCnt_q > 4'h7;
   assign currentZero   = decayCnt_q == 2'h3;
endmodule

// *** tb/dos_drive_on_off_sequencer_tb.sv ***
// bench for the on/off sequencer: apb master, scoreboard queues, watchdog
// assumes the partner model supplies speed and current feedback
module dos_drive_on_off_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      int          k;
      logic [47:0] v;
      logic [47:0] m;
   } dos_note_s;
   logic               clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic               look = 1'h0, onTerm = 1'h0, enableTerm = 1'h0, panelKey = 1'h0;
   logic               stopPb = 1'h1, parallel_torque_permit_in = 1'h0;
   logic               torqueDirRequest = 1'h0, torqueDirReqTwo = 1'h0, pot_preset_cmd = 1'h0;
   logic [7:0]         paddr = 8'h0;
   logic [31:0]        pwdata = 32'h0, seed = 32'h99c2, r;
   logic [3:0]         force_select_output = 4'h0, selectFuncLevel = 4'h0;
   logic [2:0]         changeover_cmd = 3'h0;
   logic [47:0]        changeover_default = 48'h0, changeover_source = 48'h0, ex;
   logic [15:0]        pot_preset_source = 16'h0, potNext = 16'h0;
   logic               pready, pslverr, speedLow, curZero, brake_open_out;
   logic [31:0]        prdata;
   logic [3:0]         selectOut;
   logic [47:0]        changeoverOut;
   logic [15:0]        potOut;
   logic [1:0]         torque_direction_signal_out;
   dos_pkg::dos_term_s termIn;
   dos_pkg::dos_seq_s  seqOut;
   int                 badCount = 0, checked = 0;
   logic [32:0]        rd;
   logic [32:0]        rdQ[$];
   dos_note_s          nq[$];
   dos_note_s          e;

   assign termIn = {onTerm, enableTerm, panelKey, stopPb, speedLow, curZero};
   dos_drive_on_off_sequencer #(.DataW(16)) uut (
      .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .termIn, .parallel_torque_permit_in, .torqueDirRequest, .torqueDirReqTwo,
      .force_select_output, .selectFuncLevel, .changeover_cmd, .changeover_default,
      .changeover_source, .pot_preset_cmd, .pot_preset_source, .potNext, .seqOut,
      .brake_open_out, .torque_direction_signal_out, .selectOut, .changeoverOut, .potOut);
   dos_partner part0 (.clock(clock), .rst(rst), .seqIn(seqOut), .speedBelowMin(speedLow),
      .currentZero(curZero));

   always #2.5 clock = ~clock;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic testDone();
      $display("checks %0d bad %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock);
      while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic err, input logic [31:0] d);
      rdQ.push_back({err, d});
      apb(1'h0, a, 32'h0);
   endtask

   task automatic note(input int k, input logic [47:0] v, input logic [47:0] m);
      nq.push_back('{k, v, m});
      look <= 1'h1;
      @(posedge clock);
      look <= 1'h0;
      @(posedge clock);
   endtask

   task automatic waitSeq(input logic [7:0] m, input logic [7:0] v);
      int n;
      n = 0;
      while ((8'(seqOut) & m) !== v && n < 300) begin
         @(posedge clock);
         n++;
      end
      if (n >= 300) chk(48'(8'(seqOut) & m), 48'(v));
   endtask

   // scoreboard: apb read completions and noted output samples
   always @(posedge clock) begin
      if (psel && penable && pready === 1'h1 && !pwrite && rdQ.size() > 0) begin
         rd = rdQ.pop_front();
         chk({15'h0, pslverr, prdata}, {15'h0, rd});
      end
      if (look === 1'h1) begin
         e = nq.pop_front();
         case (e.k)
            1: chk(48'(selectOut) & e.m, e.v);
            2: chk(changeoverOut, e.v);
            3: chk(48'(potOut), e.v);
            4: chk(48'(seqOut) & e.m, e.v);
            5: chk(48'(seqOut) & e.m, e.v);
            6: chk(48'(seqOut) & e.m, e.v);
            default: chk(48'(torque_direction_signal_out), e.v);
         endcase
      end
   end

   initial begin
      repeat (20000) @(posedge clock);
      chk(48'h0, 48'h1);
      testDone();
   end

   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'h0;
      rdchk(dos_pkg::OffSelFunc, 1'h0, {8'h0, dos_pkg::ResetSelFunc});
      rdchk(dos_pkg::OffControl, 1'h0, dos_pkg::ResetControl);
      rdchk(8'h40, 1'h1, 32'h0);
      // forcing, changeover, preset; select output 0 gets a function from pass 4
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         if (i == 4) apb(1'h1, dos_pkg::OffSelFunc, 32'h0008_2080);
         @(posedge clock);
         force_select_output <= r[3:0];
         selectFuncLevel <= r[7:4];
         parallel_torque_permit_in <= r[8];
         changeover_cmd <= r[11:9];
         pot_preset_cmd <= r[12];
         changeover_default <= 48'({rnd(), rnd()});
         changeover_source <= 48'({rnd(), rnd()});
         pot_preset_source <= r[31:16];
         potNext <= 16'(rnd());
         repeat (4) @(posedge clock);
         for (int j = 0; j < 3; j++)
            ex[16*j +: 16] = changeover_cmd[j] ? changeover_source[16*j +: 16]
                                               : changeover_default[16*j +: 16];
         note(1, (i >= 4) ? {44'h0, r[3:1], r[4]} : {44'h0, r[3:0]}, 48'hf);
         note(2, ex, '1);
         note(3, 48'(r[12] ? pot_preset_source : potNext), '1);
         note(7, 48'(dos_pkg::DOS_DIR_NONE), '1);
      end
      // torque direction: permit high allows one, blocks one to two, low allows two
      apb(1'h1, dos_pkg::OffNoCurrent, 32'h2);
      parallel_torque_permit_in <= 1'h1;
      torqueDirRequest <= 1'h1;
      torqueDirReqTwo <= 1'h0;
      repeat (8) @(posedge clock);
      note(7, 48'(dos_pkg::DOS_DIR_ONE), '1);
      torqueDirReqTwo <= 1'h1;
      repeat (12) @(posedge clock);
      note(7, 48'(dos_pkg::DOS_DIR_NONE), '1);
      parallel_torque_permit_in <= 1'h0;
      repeat (8) @(posedge clock);
      note(7, 48'(dos_pkg::DOS_DIR_TWO), '1);
      torqueDirRequest <= 1'h0;
      parallel_torque_permit_in <= 1'h1;
      repeat (8) @(posedge clock);
      note(7, 48'(dos_pkg::DOS_DIR_TWO), '1);
      // full switch-on and shutdown sequence with a positive brake time
      apb(1'h1, dos_pkg::OffBrakeOpen, 32'h4);
      apb(1'h1, dos_pkg::OffBrakeClose, 32'h3);
      apb(1'h1, dos_pkg::OffFieldDelay, 32'h6);
      apb(1'h1, dos_pkg::OffControl, 32'h9);
      onTerm <= 1'h1;
      enableTerm <= 1'h1;
      waitSeq(8'h20, 8'h20);
      note(4, 48'he0, 48'he5);
      onTerm <= 1'h0;
      waitSeq(8'h02, 8'h02);
      note(5, 48'he2, 48'he2);
      waitSeq(8'h80, 8'h00);
      note(5, 48'h11, 48'hf1);
      repeat (12) @(posedge clock);
      note(5, 48'h05, 48'h85);
      // control bit 0 low vetoes the terminal; then panel key replaces it
      apb(1'h1, dos_pkg::OffControl, 32'h8);
      onTerm <= 1'h1;
      repeat (20) @(posedge clock);
      note(6, 48'h0, 48'h80);
      apb(1'h1, dos_pkg::OffConfig, 32'h1);
      onTerm <= 1'h0;
      panelKey <= 1'h1;
      apb(1'h1, dos_pkg::OffBrakeOpen, 32'hffff_fffd);
      apb(1'h1, dos_pkg::OffControl, 32'h9);
      waitSeq(8'h80, 8'h80);
      note(6, 48'h80, 48'h80);
      // negative brake time: controllers first, brake opens after the time
      waitSeq(8'h60, 8'h20);
      note(4, 48'h20, 48'h60);
      waitSeq(8'h60, 8'h60);
      // edge mode: rising edge with stop low and a standing level do nothing
      apb(1'h1, dos_pkg::OffControl, 32'h8);
      waitSeq(8'h80, 8'h00);
      apb(1'h1, dos_pkg::OffConfig, 32'h4);
      stopPb <= 1'h0;
      apb(1'h1, dos_pkg::OffControl, 32'h9);
      onTerm <= 1'h1;
      repeat (20) @(posedge clock);
      note(6, 48'h0, 48'h80);
      stopPb <= 1'h1;
      repeat (20) @(posedge clock);
      note(6, 48'h0, 48'h80);
      onTerm <= 1'h0;
      repeat (6) @(posedge clock);
      onTerm <= 1'h1;
      waitSeq(8'h80, 8'h80);
      note(6, 48'h80, 48'h80);
      // withdrawing enable inhibits controllers, zero current, then pulses
      waitSeq(8'h20, 8'h20);
      enableTerm <= 1'h0;
      waitSeq(8'h20, 8'h00);
      note(4, 48'h88, 48'he8);
      waitSeq(8'h10, 8'h10);
      note(4, 48'h98, 48'hf8);
      testDone();
   end
endmodule
